// ### tb/sdl_master.sv
// bus master model driving the three-wire serial link
`timescale 1ns/10ps
module sdl_master (
	// serial link to the loader
	output logic	link_sclk,
	output logic	select_n,
	output logic	serial_data_in
);
	localparam real HALF = 80.0;	// half of the 160 ns link period
	// idle: deselected, clock stopped low
	initial begin
		link_sclk = 1'b0;
		select_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// n bits MSB first, data moved on falling edges; odd start keeps phase off the system grid
	task automatic send(input logic [31:0] bits, input int n);
		#3.3 select_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in = bits[i];
			#HALF link_sclk = 1'b1;
			#HALF link_sclk = 1'b0;
		end
		#HALF select_n = 1'b1;
		serial_data_in = ~serial_data_in; // no stale bit once released
		#HALF;
	endtask : send
	// clock pulses while deselected, which the loader must ignore
	task automatic wiggle(input int n);
		repeat (n) begin
			serial_data_in = ~serial_data_in;
			#HALF link_sclk = 1'b1;
			#HALF link_sclk = 1'b0;
		end
	endtask : wiggle
endmodule : sdl_master

// ### tb/sdl_sva.sv
// assertion checker for the serial word loader ports
`timescale 1ns/10ps
module sdl_sva (
	// clock and reset
	input wire logic	sys_clk,
	input wire logic	reset,
	// serial link and load level
	input wire logic	link_sclk,
	input wire logic	select_n,
	input wire logic	serial_data_in,
	input wire logic	load_latch_n,
	// word and switch outputs
	input wire logic [sdl_pkg::WORD_W-1:0]	input_word,
	input wire logic [sdl_pkg::WORD_W-1:0]	latch_code,
	input wire logic [sdl_pkg::SEG_N-1:0]	segment_en,
	input wire logic [sdl_pkg::LADDER_W-1:0]	ladder_drive
);
	import sdl_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic	sel_q;	// select seen at the last edge
	logic [3:0]	since_rise;	// edges since select rose, saturating
	logic [SEG_N-1:0]	seg_exp;	// thermometer wanted for the latch
	// age of the last frame end; the input register may only move shortly after one
	always_ff @(posedge sys_clk) begin
		sel_q <= select_n;
		if (reset) begin
			since_rise <= 4'hF;
		end else if (select_n && !sel_q) begin
			since_rise <= 4'h0;
		end else if (since_rise != 4'hF) begin
			since_rise <= since_rise + 4'h1;
		end
	end
	// decode of the upper nibble
	always_comb begin
		for (int i = 0; i < SEG_N; i++) begin
			seg_exp[i] = (latch_code[15:12] > i);
		end
	end
	a_reset_midscale: assert property ($past(reset) |-> latch_code == MIDSCALE && input_word == MIDSCALE)
		else $error("not mid-scale after reset");
	a_ladder_low_bits: assert property (ladder_drive == latch_code[11:0])
		else $error("ladder drive wrong");
	a_segment_thermo: assert property (segment_en == seg_exp)
		else $error("segment enables wrong");
	a_input_after_frame: assert property ($changed(input_word) |-> since_rise inside {[4'h1:4'h7]})
		else $error("input word moved without frame end");
	a_input_hold_frame: assert property ((!select_n)[*3] |=> $stable(input_word))
		else $error("input word moved in frame");
	a_latch_hold_load: assert property ((load_latch_n)[*5] |-> $stable(latch_code))
		else $error("latch moved with load high");
	a_latch_follows: assert property ((!load_latch_n && select_n)[*5] |-> latch_code == $past(input_word))
		else $error("latch not following input");
	a_latch_from_input: assert property ($changed(latch_code) |-> latch_code == $past(input_word))
		else $error("latch took a foreign value");
	c_frame_end: cover property ($rose(select_n));
	c_latch_moves: cover property ($changed(latch_code));
	c_tied_load: cover property (!load_latch_n && $changed(input_word));
endmodule : sdl_sva
bind sdl_word_loader sdl_sva chk (.sys_clk(sys_clk), .reset(reset), .link_sclk(link_sclk), .select_n(select_n),
	.serial_data_in(serial_data_in), .load_latch_n(load_latch_n), .input_word(input_word),
	.latch_code(latch_code), .segment_en(segment_en), .ladder_drive(ladder_drive));

// ### tb/tb.sv
// self-checking bench for the serial word loader
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
	import sdl_pkg::*;
	logic	sys_clk, reset, load_latch_n;	// bench-driven inputs
	wire logic	link_sclk, select_n, serial_data_in;	// from the master model
	logic [WORD_W-1:0]	input_word, latch_code;
	logic [SEG_N-1:0]	segment_en;
	logic [LADDER_W-1:0]	ladder_drive;
	logic [WORD_W-1:0]	shift_mdl, in_mdl, latch_mdl;	// models of the three registers
	logic [31:0]	r;	// random draw
	int	mismatches = 0, checks = 0, cycles = 0, seed = 59;
	sdl_master master (.link_sclk(link_sclk), .select_n(select_n), .serial_data_in(serial_data_in));
	sdl_word_loader DUT (.sys_clk(sys_clk), .reset(reset), .link_sclk(link_sclk), .select_n(select_n),
		.serial_data_in(serial_data_in), .load_latch_n(load_latch_n), .input_word(input_word),
		.latch_code(latch_code), .segment_en(segment_en), .ladder_drive(ladder_drive));
	// thermometer code for an upper nibble
	function automatic logic [SEG_N-1:0] thermo(input logic [3:0] nib);
		thermo = '0;
		for (int i = 0; i < SEG_N; i++) begin
			thermo[i] = (nib > i);
		end
	endfunction : thermo
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	// all four outputs against the models
	task automatic check_all();
		`CHK("input_word", in_mdl, input_word)
		`CHK("latch_code", latch_mdl, latch_code)
		`CHK("segment_en", thermo(latch_mdl[15:12]), segment_en)
		`CHK("ladder_drive", latch_mdl[11:0], ladder_drive)
	endtask : check_all
	// one frame of n bits; outputs settle well within ten edges of its end
	task automatic frame(input logic [31:0] bits, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			shift_mdl = {shift_mdl[WORD_W-2:0], bits[i]}; // MSB first, last 16 kept
		end
		master.send(bits, n);
		repeat (10) @(posedge sys_clk);
		#1;
		in_mdl = shift_mdl;
		if (!load_latch_n) begin
			latch_mdl = in_mdl;
		end
		check_all();
	endtask : frame
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// a hung run is cut short well past the expected length
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		reset = 1'b1;
		load_latch_n = 1'b1;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		in_mdl = MIDSCALE;
		latch_mdl = MIDSCALE;
		check_all();
		r = $random(seed);
		frame(r, 16); // full first word, latch deferred
		@(posedge sys_clk) load_latch_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		latch_mdl = in_mdl;
		check_all();
		for (int k = 0; k < 16; k++) begin
			r = $random(seed);
			frame({16'h0000, k[3:0], r[11:0]}, 16); // each nibble, load tied low
		end
		r = $random(seed);
		frame(r, 20); // overlong frame
		@(posedge sys_clk) load_latch_n <= 1'b1;
		master.wiggle(6);
		repeat (4) @(posedge sys_clk);
		#1;
		check_all(); // deselected clocks ignored
		frame(r, 8); // short frame keeps older bits
		@(posedge sys_clk) reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		in_mdl = MIDSCALE;
		latch_mdl = MIDSCALE;
		check_all();
		frame(32'h0000005A, 8); // shift register survives reset
		give_verdict();
	end
endmodule : tb

// ### verilog/sdl_pkg.sv
// constants and types shared by the serial word loader
package sdl_pkg;

	// word and split widths
	localparam int WORD_W   = 16;
	localparam int SEG_BITS = 4;
	localparam int SEG_N    = 15;
	localparam int LADDER_W = 12;

	// mid-scale code loaded at reset
	localparam logic [WORD_W-1:0] MIDSCALE = 16'h8000;

	// thermometer pattern that matches the mid-scale upper nibble
	localparam logic [SEG_N-1:0] SEG_RESET = 15'h00FF;

	// ladder drive that matches the mid-scale lower bits
	localparam logic [LADDER_W-1:0] LADDER_RESET = 12'h000;

	// depth of the buffer between capture and input register
	localparam int BUF_DEPTH = 2;

	// capture stage states, one-hot
	typedef enum logic [1:0] {
		SDL_CAP_IDLE = 2'b01,
		SDL_CAP_PEND = 2'b10
	} sdl_cap_t;

endpackage : sdl_pkg

// ### verilog/sdl_word_buf.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
module sdl_word_buf #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	// control state kept in one packed struct
	typedef struct packed {
		logic [PTR_W-1:0] wr_ptr;   // next slot to write
		logic [PTR_W-1:0] rd_ptr;   // next slot to read
		logic [CNT_W-1:0] count;    // words held
	} sdl_buf_t;

	sdl_buf_t          buf_reg;      // registered control
	sdl_buf_t          buf_next;     // next control
	logic [WIDTH-1:0]  mem [DEPTH];  // word storage
	logic              push;         // accepted write
	logic              pop;          // accepted read

	// honest flags straight from the count
	assign in_ready  = (buf_reg.count != CNT_W'(DEPTH));
	assign out_valid = (buf_reg.count != '0);
	assign out_data  = mem[buf_reg.rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointer and count update, wrap at depth
	always_comb begin
		buf_next = buf_reg;
		if (push) begin
			buf_next.wr_ptr = (buf_reg.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : buf_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			buf_next.rd_ptr = (buf_reg.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : buf_reg.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			buf_next.count = buf_reg.count + 1'b1;
		end else if (pop && !push) begin
			buf_next.count = buf_reg.count - 1'b1;
		end
	end

	// control registers, synchronous reset empties the buffer
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			buf_reg <= '0;
		end else begin
			buf_reg <= buf_next;
		end
	end

	// storage needs no reset, valid is tracked by the count
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[buf_reg.wr_ptr] <= in_data;
		end
	end

endmodule : sdl_word_buf

// ### verilog/sdl_word_loader.sv
// serial word loader: link shift register, input register, converter latch and decode
`timescale 1ns/10ps
module sdl_word_loader (
	// system clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	// serial link from the bus master
	input  wire logic                          link_sclk,
	input  wire logic                          select_n,
	input  wire logic                          serial_data_in,
	// latch load control
	input  wire logic                          load_latch_n,
	// word outputs
	output logic      [sdl_pkg::WORD_W-1:0]    input_word,
	output logic      [sdl_pkg::WORD_W-1:0]    latch_code,
	// converter switch drives
	output logic      [sdl_pkg::SEG_N-1:0]     segment_en,
	output logic      [sdl_pkg::LADDER_W-1:0]  ladder_drive
);
	import sdl_pkg::*;

	// ------------------------------------------------------------------
	// link domain: runs only on the master's serial clock
	// ------------------------------------------------------------------

	// link state in one packed struct
	typedef struct packed {
		logic [WORD_W-1:0] shift;   // serial shift register
	} sdl_link_t;

	sdl_link_t link_reg;   // registered link state
	sdl_link_t link_next;  // next link state

	// shift in on every rising serial edge while selected
	always_comb begin
		link_next = link_reg;
		// select high: serial clock and data have no effect
		if (!select_n) begin
			// msb arrives first, so older bits move up;
			// extra bits push the oldest out, keeping the last 16
			link_next.shift = {link_reg.shift[WORD_W-2:0], serial_data_in};
		end
	end

	// no reset here on purpose: contents after power-up are undefined,
	// and the clock may stand still outside frames anyway
	always_ff @(posedge link_sclk) begin
		link_reg <= link_next;
	end

	// ------------------------------------------------------------------
	// system domain
	// ------------------------------------------------------------------

	// system state in one packed struct
	typedef struct packed {
		logic              sel_meta;     // select synchroniser, first stage
		logic              sel_sync;     // select synchroniser, second stage
		logic              sel_prev;     // select delayed for edge detect
		logic              ld_meta;      // load synchroniser, first stage
		logic              ld_sync;      // load synchroniser, second stage
		sdl_cap_t          cap_state;    // capture stage state
		logic [WORD_W-1:0] cap_word;     // word taken from the link
		logic              drain_hold;   // one-cycle stall after a pop
		logic [WORD_W-1:0] input_word;   // input register
		logic [WORD_W-1:0] latch_word;   // converter latch
		logic [SEG_N-1:0]  seg_en;       // thermometer segment enables
		logic [LADDER_W-1:0] ladder;     // ladder switch drives
	} sdl_sys_t;

	sdl_sys_t          sys_reg;      // registered system state
	sdl_sys_t          sys_next;     // next system state

	// buffer handshake wires
	logic              buf_in_valid;  // capture stage offers a word
	logic              buf_in_ready;  // buffer has room
	logic              buf_out_valid; // buffer holds a word
	logic              buf_out_ready; // input register takes a word
	logic [WORD_W-1:0] buf_out_data;  // word at the buffer head

	// select edge seen in the system domain
	logic              sel_rise;

	// thermometer decode of the upper bits of a code
	function automatic logic [SEG_N-1:0] therm_decode(input logic [SEG_BITS-1:0] nib);
		logic [SEG_N-1:0] t;
		t = '0;
		for (int i = 0; i < SEG_N; i++) begin
			// segment i is on once the nibble exceeds i
			t[i] = (nib > SEG_BITS'(i));
		end
		return t;
	endfunction : therm_decode

	// the capture stage offers its word whenever it is pending
	assign buf_in_valid  = (sys_reg.cap_state == SDL_CAP_PEND);

	// the input register stalls one cycle after each take, so that
	// a transparent latch always sees each word for two cycles
	assign buf_out_ready = !sys_reg.drain_hold;

	// rising select, taken from synchronised copies only
	assign sel_rise = sys_reg.sel_sync & !sys_reg.sel_prev;

	// two-entry buffer between the link capture and the input register;
	// a stall on the draining side backs up into the capture stage
	sdl_word_buf #(
		.WIDTH (WORD_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (sys_reg.cap_word),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	// next-state logic for the whole system domain
	always_comb begin
		sys_next = sys_reg;

		// two-stage synchronisers for the select and load pins
		sys_next.sel_meta = select_n;
		sys_next.sel_sync = sys_reg.sel_meta;
		sys_next.sel_prev = sys_reg.sel_sync;
		sys_next.ld_meta  = load_latch_n;
		sys_next.ld_sync  = sys_reg.ld_meta;

		// capture stage: take the shift register once select has risen.
		// the link word is quasi-static here: with select high the
		// shift register cannot move, so the multi-bit read is safe
		unique case (sys_reg.cap_state)
			SDL_CAP_IDLE: begin
				if (sel_rise) begin
					sys_next.cap_word  = link_reg.shift;
					sys_next.cap_state = SDL_CAP_PEND;
				end
			end
			SDL_CAP_PEND: begin
				if (sel_rise) begin
					// a newer frame replaces a word still waiting
					sys_next.cap_word  = link_reg.shift;
				end else if (buf_in_ready) begin
					sys_next.cap_state = SDL_CAP_IDLE;
				end
			end
			default: begin
				// illegal code: recover to idle
				sys_next.cap_state = SDL_CAP_IDLE;
			end
		endcase

		// input register pops the buffer head, then rests a cycle
		sys_next.drain_hold = 1'b0;
		if (buf_out_valid && buf_out_ready) begin
			sys_next.input_word = buf_out_data;
			sys_next.drain_hold = 1'b1;
		end

		// latch is level sensitive: while load is low and select is
		// high it keeps copying the input register; tied low it
		// follows every new word one cycle after the input register
		if (!sys_reg.ld_sync && sys_reg.sel_sync) begin
			sys_next.latch_word = sys_reg.input_word;
		end

		// decode of the latch contents, registered with the latch so
		// the switch drives never disagree with the code for a cycle
		sys_next.seg_en = therm_decode(sys_next.latch_word[WORD_W-1 -: SEG_BITS]);
		sys_next.ladder = sys_next.latch_word[LADDER_W-1:0];
	end

	// system registers; reset sets mid-scale in input and latch.
	// select and load synchronisers reset to the idle high level so
	// the first cycles after reset show no false select edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sys_reg.sel_meta   <= 1'b1;
			sys_reg.sel_sync   <= 1'b1;
			sys_reg.sel_prev   <= 1'b1;
			sys_reg.ld_meta    <= 1'b1;
			sys_reg.ld_sync    <= 1'b1;
			sys_reg.cap_state  <= SDL_CAP_IDLE;
			sys_reg.cap_word   <= MIDSCALE;
			sys_reg.drain_hold <= 1'b0;
			sys_reg.input_word <= MIDSCALE;
			sys_reg.latch_word <= MIDSCALE;
			sys_reg.seg_en     <= SEG_RESET;
			sys_reg.ladder     <= LADDER_RESET;
		end else begin
			sys_reg <= sys_next;
		end
	end

	// outputs come straight from the state flip-flops
	assign input_word   = sys_reg.input_word;
	assign latch_code   = sys_reg.latch_word;
	assign segment_en   = sys_reg.seg_en;
	assign ladder_drive = sys_reg.ladder;

endmodule : sdl_word_loader
